// *** hw/spl_loader.sv ***
`timescale 1ns/1ps
`default_nettype none
module spl_loader
	import spl_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// process pins and internal store status
	input wire logic [IN_W-1:0] pin_in,
	input wire logic int_prog_valid_in,
	output logic [OUT_W-1:0] pin_out,
	// cartridge
	input wire logic cart_present_in,
	input wire logic cart_protect_in,
	input wire logic [PW_W-1:0] cart_password_in,
	input wire logic cart_ack_in,
	input wire logic [WORD_W-1:0] cart_data_in,
	output logic cart_req_out,
	output logic [ADDR_W-1:0] cart_addr_out,
	// host link, from the cable front end on this clock
	input wire logic cable_in,
	input wire logic host_wr_in,
	input wire logic [ADDR_W-1:0] host_addr_in,
	input wire logic [WORD_W-1:0] host_data_in,
	input wire logic host_start_in,
	input wire logic host_stop_in,
	input wire logic host_pw_valid_in,
	input wire logic [PW_W-1:0] host_pw_in,
	input wire logic host_rd_in,
	output logic [PROG_WORDS-1:0] live_data_out,
	output logic live_ok_out,
	output logic live_refused_out,
	// lamps
	output logic red_lamp_out,
	output logic green_lamp_out
);
	function automatic logic is_run(input spl_state_t s);
		return (s == ST_SAMPLE) || (s == ST_EVAL) || (s == ST_UPDATE);
	endfunction

	function automatic logic eval_word(input logic [WORD_W-1:0] w,
		input logic [IN_W-1:0] img);
		logic a;
		logic b;
		a = img[w[SRCA_MSB:SRCA_LSB]];
		b = img[w[SRCB_MSB:SRCB_LSB]];
		unique case (spl_op_t'(w[OP_MSB:OP_LSB]))
			OP_AND: return a & b;
			OP_OR: return a | b;
			OP_XOR: return a ^ b;
			OP_NOTA: return ~a;
		endcase
	endfunction

	// pin synchronisers; stage one is read only by stage two
	logic [SYNC_W-1:0] sync1_r, sync2_r;
	logic cart_s, prot_s, ack_s, cable_s;
	logic [PW_W-1:0] pw_s;
	logic [WORD_W-1:0] cdata_s;
	logic [IN_W-1:0] in_s;

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_r <= SYNC_RST;
			sync2_r <= SYNC_RST;
		end else begin
			sync1_r <= {cart_present_in, cart_protect_in, cart_password_in,
				cart_ack_in, cart_data_in, cable_in, pin_in};
			sync2_r <= sync1_r;
		end
	end
	assign {cart_s, prot_s, pw_s, ack_s, cdata_s, cable_s, in_s} = sync2_r;

	logic copy_start_r, copy_start_nxt, copy_done, cp_wr;
	logic [ADDR_W-1:0] cp_addr;
	logic [WORD_W-1:0] cp_data;

	spl_copier u_copier (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.start_in(copy_start_r),
		.done_out(copy_done),
		.ack_in(ack_s),
		.data_in(cdata_s),
		.req_out(cart_req_out),
		.addr_out(cart_addr_out),
		.wr_en_out(cp_wr),
		.wr_addr_out(cp_addr),
		.wr_data_out(cp_data)
	);

	spl_state_t state_r, state_nxt;
	logic [WORD_W-1:0] mem_r [PROG_WORDS];
	logic [WORD_W-1:0] mem_nxt [PROG_WORDS];
	logic [1:0] boot_r, boot_nxt;
	logic valid_r, valid_nxt, prot_r, prot_nxt, unlock_r, unlock_nxt;
	logic cart_prev_r, cart_prev_nxt;
	logic [ADDR_W-1:0] pc_r, pc_nxt;
	logic [IN_W-1:0] img_r, img_nxt;
	logic [PROG_WORDS-1:0] func_r, func_nxt, live_r, live_nxt;
	logic [OUT_W-1:0] out_r, out_nxt;
	logic ok_r, ok_nxt, ref_r, ref_nxt, red_r, red_nxt, green_r, green_nxt;
	logic erase_w, link_ok, may_read;

	// a protected program must not outlive its cartridge
	assign erase_w = prot_r && cart_prev_r && !cart_s;
	assign link_ok = cable_s;
	assign may_read = is_run(state_r) && (!prot_r || unlock_r);

	always_comb begin
		state_nxt = state_r;
		mem_nxt = mem_r;
		boot_nxt = boot_r;
		valid_nxt = valid_r;
		prot_nxt = prot_r;
		unlock_nxt = unlock_r;
		cart_prev_nxt = cart_s;
		pc_nxt = pc_r;
		img_nxt = img_r;
		func_nxt = func_r;
		out_nxt = out_r;
		live_nxt = live_r;
		ok_nxt = 1'b0;
		ref_nxt = 1'b0;
		copy_start_nxt = 1'b0;
		// no button path exists; only boot sequencing, the host and removal of a protected cartridge move state
		unique case (state_r)
			ST_BOOT: begin
				// let the synchronisers fill before looking at the cartridge
				if (boot_r == BOOT_SETTLE) begin
					valid_nxt = int_prog_valid_in;
					state_nxt = ST_CHECK;
				end else begin
					boot_nxt = boot_r + BOOT_ONE;
				end
			end
			ST_CHECK: begin
				if (cart_s) begin
					valid_nxt = 1'b0;
					prot_nxt = 1'b0;
					copy_start_nxt = 1'b1;
					state_nxt = ST_COPY;
				end else if (valid_r) begin
					state_nxt = ST_SAMPLE;
				end else begin
					state_nxt = ST_STOP;
				end
			end
			ST_COPY: begin
				if (copy_done) begin
					valid_nxt = 1'b1;
					prot_nxt = prot_s;
					unlock_nxt = 1'b0;
					state_nxt = ST_SAMPLE;
				end
			end
			ST_STOP: begin
				if (host_start_in && link_ok && valid_r) begin
					state_nxt = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				img_nxt = in_s;
				pc_nxt = ADDR_ZERO;
				state_nxt = ST_EVAL;
			end
			ST_EVAL: begin
				func_nxt[pc_r] = eval_word(mem_r[pc_r], img_r);
				pc_nxt = pc_r + ADDR_ONE;
				if (pc_r == ADDR_LAST) begin
					state_nxt = ST_UPDATE;
				end
			end
			ST_UPDATE: begin
				out_nxt = func_r[OUT_W-1:0];
				state_nxt = ST_SAMPLE;
			end
			default: begin
				state_nxt = ST_STOP;
			end
		endcase
		if (cp_wr) begin
			mem_nxt[cp_addr] = cp_data;
		end
		if (link_ok && host_stop_in && is_run(state_r)) begin
			state_nxt = ST_STOP;
		end
		// a download always lands in stop; start is a separate command
		if (link_ok && host_wr_in && (state_r == ST_STOP ||
			is_run(state_r))) begin
			mem_nxt[host_addr_in] = host_data_in;
			valid_nxt = 1'b1;
			prot_nxt = 1'b0;
			state_nxt = ST_STOP;
		end
		if (link_ok && host_pw_valid_in) begin
			unlock_nxt = (host_pw_in == pw_s);
		end
		if (erase_w) begin
			for (int i = 0; i < PROG_WORDS; i++) begin
				mem_nxt[i] = WORD_RST;
			end
			valid_nxt = 1'b0;
			prot_nxt = 1'b0;
			unlock_nxt = 1'b0;
			state_nxt = ST_STOP;
		end
		if (link_ok && host_rd_in) begin
			if (may_read) begin
				live_nxt = func_r;
				ok_nxt = 1'b1;
			end else begin
				ref_nxt = 1'b1;
			end
		end
		// outputs go safe whenever the program is not running
		if (!is_run(state_nxt)) begin
			out_nxt = OUT_RST;
		end
		red_nxt = !is_run(state_nxt);
		green_nxt = is_run(state_nxt);
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= ST_BOOT;
			for (int i = 0; i < PROG_WORDS; i++) begin
				mem_r[i] <= WORD_RST;
			end
			boot_r <= BOOT_ZERO;
			valid_r <= 1'b0;
			prot_r <= 1'b0;
			unlock_r <= 1'b0;
			cart_prev_r <= 1'b0;
			pc_r <= ADDR_ZERO;
			img_r <= IMG_RST;
			func_r <= IMG_RST;
			out_r <= OUT_RST;
			live_r <= IMG_RST;
			ok_r <= 1'b0;
			ref_r <= 1'b0;
			copy_start_r <= 1'b0;
			red_r <= 1'b1;
			green_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			mem_r <= mem_nxt;
			boot_r <= boot_nxt;
			valid_r <= valid_nxt;
			prot_r <= prot_nxt;
			unlock_r <= unlock_nxt;
			cart_prev_r <= cart_prev_nxt;
			pc_r <= pc_nxt;
			img_r <= img_nxt;
			func_r <= func_nxt;
			out_r <= out_nxt;
			live_r <= live_nxt;
			ok_r <= ok_nxt;
			ref_r <= ref_nxt;
			copy_start_r <= copy_start_nxt;
			red_r <= red_nxt;
			green_r <= green_nxt;
		end
	end

	assign pin_out = out_r;
	assign live_data_out = live_r;
	assign live_ok_out = ok_r;
	assign live_refused_out = ref_r;
	assign red_lamp_out = red_r;
	assign green_lamp_out = green_r;

	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);

	chk_phase_order: assert property ((state_r == ST_SAMPLE) |=>
		(state_r == ST_EVAL || state_r == ST_STOP)) else $error("bad phase");
	chk_empty_stop: assert property ((state_r == ST_CHECK && !cart_s && !valid_r)
		|=> state_r == ST_STOP) else $error("empty boot ran");
	chk_auto_run: assert property ((state_r == ST_CHECK && !cart_s && valid_r)
		|=> state_r == ST_SAMPLE) else $error("no auto run");
	chk_cart_first: assert property ((state_r == ST_CHECK && cart_s) |=>
		(state_r == ST_COPY && copy_start_r)) else $error("copy skipped");
	chk_copy_run: assert property ((state_r == ST_COPY && copy_done && !erase_w)
		|=> (state_r == ST_SAMPLE && valid_r)) else $error("no run after copy");
	chk_stop_hold: assert property ((state_r == ST_STOP && !host_start_in) |=>
		state_r == ST_STOP) else $error("stop left without host");
	chk_host_start: assert property ((state_r == ST_STOP && host_start_in &&
		cable_s && valid_r && !host_wr_in && !erase_w) |=>
		state_r == ST_SAMPLE) else $error("host start ignored");
	chk_red_lamp: assert property (red_lamp_out == !is_run(state_r))
		else $error("red lamp wrong");
	chk_green_lamp: assert property (green_lamp_out == is_run(state_r))
		else $error("green lamp wrong");
	chk_live_read: assert property ((host_rd_in && cable_s && is_run(state_r)
		&& !prot_r) |=> (live_ok_out && live_data_out == $past(func_r)))
		else $error("live read lost");
	chk_read_lock: assert property ((host_rd_in && cable_s && prot_r && !unlock_r)
		|=> (live_refused_out && !live_ok_out)) else $error("lock open");
	chk_erase_prog: assert property (erase_w |=> (!valid_r &&
		state_r == ST_STOP ##1 red_lamp_out)) else $error("no erase");
endmodule // spl_loader
`default_nettype wire

// *** common/spl_pkg.sv ***
// Contract
// - each run cycle samples inputs, evaluates program, then updates outputs
// - with no program anywhere at power-on, stay in stop
// - valid internal program at power-on enters run without operator action
// - inserted cartridge is copied into internal memory, overwriting it
// - after the cartridge copy, switch from stop to run automatically
// - no button start or stop; only power-up or host link change state (the code also stops when a protected cartridge is removed)
// - with cable attached, host may download a program and start it
// - red lamp lit from power-on in every state except run
// - green lamp lit whenever in run
// - host may read live function values while in run
// - protected cartridge blocks live reads until correct password given
// - removing a protected cartridge erases the copied program
package spl_pkg;
	localparam int PROG_WORDS = 8;
	localparam int ADDR_W = 3;
	localparam int WORD_W = 8;
	localparam int IN_W = 8;
	localparam int OUT_W = 4;
	localparam int PW_W = 16;
	localparam int SYNC_W = 36;
	localparam int OP_MSB = 7;
	localparam int OP_LSB = 6;
	localparam int SRCA_MSB = 5;
	localparam int SRCA_LSB = 3;
	localparam int SRCB_MSB = 2;
	localparam int SRCB_LSB = 0;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 3'h7;
	localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
	localparam logic [IN_W-1:0] IMG_RST = 8'h00;
	localparam logic [OUT_W-1:0] OUT_RST = 4'h0;
	localparam logic [SYNC_W-1:0] SYNC_RST = 36'h0;
	localparam logic [1:0] BOOT_SETTLE = 2'h3;
	localparam logic [1:0] BOOT_ZERO = 2'h0;
	localparam logic [1:0] BOOT_ONE = 2'h1;

	typedef enum logic [1:0] {
		OP_AND = 2'h0,
		OP_OR = 2'h1,
		OP_XOR = 2'h2,
		OP_NOTA = 2'h3
	} spl_op_t;

	typedef enum logic [6:0] {
		ST_BOOT = 7'h01,
		ST_CHECK = 7'h02,
		ST_COPY = 7'h04,
		ST_STOP = 7'h08,
		ST_SAMPLE = 7'h10,
		ST_EVAL = 7'h20,
		ST_UPDATE = 7'h40
	} spl_state_t;

	typedef enum logic [2:0] {
		CP_IDLE = 3'h1,
		CP_REQ = 3'h2,
		CP_REL = 3'h4
	} spl_cp_state_t;
endpackage

// *** hw/spl_copier.sv ***
`timescale 1ns/1ps
`default_nettype none
module spl_copier
	import spl_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// control
	input wire logic start_in,
	output logic done_out,
	// cartridge handshake, already synchronised
	input wire logic ack_in,
	input wire logic [WORD_W-1:0] data_in,
	output logic req_out,
	output logic [ADDR_W-1:0] addr_out,
	// internal memory write
	output logic wr_en_out,
	output logic [ADDR_W-1:0] wr_addr_out,
	output logic [WORD_W-1:0] wr_data_out
);
	spl_cp_state_t st_r, st_nxt;
	logic req_r, req_nxt, done_r, done_nxt, wr_r, wr_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [WORD_W-1:0] wd_r, wd_nxt;

	// full four-phase handshake: slow cartridge timing does not matter
	always_comb begin
		st_nxt = st_r;
		req_nxt = req_r;
		done_nxt = 1'b0;
		wr_nxt = 1'b0;
		addr_nxt = addr_r;
		wd_nxt = wd_r;
		unique case (st_r)
			CP_IDLE: begin
				if (start_in) begin
					addr_nxt = ADDR_ZERO;
					req_nxt = 1'b1;
					st_nxt = CP_REQ;
				end
			end
			CP_REQ: begin
				if (ack_in) begin
					wr_nxt = 1'b1;
					wd_nxt = data_in;
					req_nxt = 1'b0;
					st_nxt = CP_REL;
				end
			end
			CP_REL: begin
				if (!ack_in) begin
					if (addr_r == ADDR_LAST) begin
						done_nxt = 1'b1;
						st_nxt = CP_IDLE;
					end else begin
						addr_nxt = addr_r + ADDR_ONE;
						req_nxt = 1'b1;
						st_nxt = CP_REQ;
					end
				end
			end
			default: begin
				req_nxt = 1'b0;
				st_nxt = CP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r <= CP_IDLE;
			req_r <= 1'b0;
			done_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= ADDR_ZERO;
			wd_r <= WORD_RST;
		end else begin
			st_r <= st_nxt;
			req_r <= req_nxt;
			done_r <= done_nxt;
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			wd_r <= wd_nxt;
		end
	end

	assign done_out = done_r;
	assign req_out = req_r;
	assign addr_out = addr_r;
	assign wr_en_out = wr_r;
	assign wr_addr_out = addr_r;
	assign wr_data_out = wd_r;

	chk_req_drop: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(st_r == CP_REQ && ack_in) |=> (!req_r && wr_r)) else $error("copy word not taken");
endmodule // spl_copier
`default_nettype wire

// *** tb/spl_cart_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spl_cart_model
	import spl_pkg::*;
(
	// clock
	input wire logic clock_in,
	// loader side of the handshake
	input wire logic req_in,
	input wire logic [ADDR_W-1:0] addr_in,
	output logic ack_out,
	output logic [WORD_W-1:0] data_out,
	// card contents and pace
	input wire logic [PROG_WORDS*WORD_W-1:0] image_in,
	input wire logic slow_in
);
	int wait_c;
	initial begin
		ack_out = 1'b0;
		data_out = 8'h00;
		wait_c = 0;
	end
	// slow pace on odd words only, so both answer speeds are seen
	always @(posedge clock_in) begin
		// no word offered: keep the lines moving so nothing stale is read
		if (!ack_out)
			data_out <= ~data_out;
		if (req_in && !ack_out) begin
			wait_c++;
			if (wait_c > ((slow_in && addr_in[0]) ? 6 : 1)) begin
				data_out <= image_in[addr_in*WORD_W +: WORD_W];
				ack_out <= 1'b1;
				wait_c = 0;
			end
		end else if (!req_in && ack_out) begin
			ack_out <= 1'b0;
		end
	end
endmodule // spl_cart_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
	import spl_pkg::*;
;
	logic clock_in, resetn_in, int_prog_valid_in, cart_present_in;
	logic cart_protect_in, cart_ack_in, cable_in, host_wr_in, host_start_in;
	logic host_stop_in, host_pw_valid_in, host_rd_in, live_ok_out;
	logic live_refused_out, red_lamp_out, green_lamp_out, cart_req_out, slow;
	logic [IN_W-1:0] pin_in;
	logic [OUT_W-1:0] pin_out;
	logic [PW_W-1:0] cart_password_in, host_pw_in;
	logic [WORD_W-1:0] cart_data_in, host_data_in, w;
	logic [ADDR_W-1:0] cart_addr_out, host_addr_in;
	logic [PROG_WORDS-1:0] live_data_out;
	logic [PROG_WORDS*WORD_W-1:0] prog, card;
	logic [8:0] e;
	logic [8:0] expq[$];
	int miscompares, tests_run;

	spl_loader u_spl_loader (.clock_in(clock_in), .resetn_in(resetn_in),
		.pin_in(pin_in), .int_prog_valid_in(int_prog_valid_in),
		.pin_out(pin_out), .cart_present_in(cart_present_in),
		.cart_protect_in(cart_protect_in), .cart_password_in(cart_password_in),
		.cart_ack_in(cart_ack_in), .cart_data_in(cart_data_in),
		.cart_req_out(cart_req_out), .cart_addr_out(cart_addr_out),
		.cable_in(cable_in), .host_wr_in(host_wr_in),
		.host_addr_in(host_addr_in), .host_data_in(host_data_in),
		.host_start_in(host_start_in), .host_stop_in(host_stop_in),
		.host_pw_valid_in(host_pw_valid_in), .host_pw_in(host_pw_in),
		.host_rd_in(host_rd_in), .live_data_out(live_data_out),
		.live_ok_out(live_ok_out), .live_refused_out(live_refused_out),
		.red_lamp_out(red_lamp_out), .green_lamp_out(green_lamp_out));

	spl_cart_model u_spl_cart_model (.clock_in(clock_in),
		.req_in(cart_req_out), .addr_in(cart_addr_out), .ack_out(cart_ack_in),
		.data_out(cart_data_in), .image_in(card), .slow_in(slow));

	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end

	function automatic logic [7:0] fn(input logic [63:0] p,
		input logic [7:0] im);
		logic [7:0] x;
		logic a, b;
		fn = 8'h00;
		for (int i = 0; i < 8; i++) begin
			x = p[i*8 +: 8];
			a = im[x[5:3]];
			b = im[x[2:0]];
			case (x[7:6])
				2'h0: fn[i] = a & b;
				2'h1: fn[i] = a | b;
				2'h2: fn[i] = a ^ b;
				default: fn[i] = ~a;
			endcase
		end
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_lamps(input logic [1:0] x);
		chk({7'h00, red_lamp_out, green_lamp_out}, {7'h00, x});
	endtask

	task automatic chk_pins(input logic [63:0] p);
		logic [7:0] f;
		f = fn(p, pin_in);
		chk({5'h00, pin_out}, {5'h00, f[3:0]});
	endtask

	task automatic chk_read(input logic [8:0] x);
		chk({live_ok_out, live_ok_out === 1'b1 ? live_data_out : 8'h00}, x);
	endtask

	// one pulse: 0 start, 1 stop, 2 password, 3 read
	task automatic hop(input int k, input logic [15:0] v);
		@(posedge clock_in);
		host_start_in <= (k == 0);
		host_stop_in <= (k == 1);
		host_pw_valid_in <= (k == 2);
		host_rd_in <= (k == 3);
		host_pw_in <= v;
		@(posedge clock_in);
		{host_start_in, host_stop_in, host_pw_valid_in, host_rd_in} <= 4'h0;
	endtask

	task automatic rd(input logic ok, input logic [7:0] d);
		expq.push_back({ok, ok ? d : 8'h00});
		hop(3, 16'h0000);
	endtask

	task automatic hwr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_in);
		host_wr_in <= 1'b1;
		host_addr_in <= a;
		host_data_in <= d;
		@(posedge clock_in);
		host_wr_in <= 1'b0;
	endtask

	// waits for run up to a bound; a stop outcome just runs the bound out
	task automatic boot(input logic v, input logic c, input logic p);
		@(posedge clock_in);
		resetn_in <= 1'b0;
		int_prog_valid_in <= v;
		cart_present_in <= c;
		cart_protect_in <= p;
		tick(16);
		resetn_in <= 1'b1;
		tick(1);
		chk_lamps(2'h2);
		for (int i = 0; i < 600 && green_lamp_out !== 1'b1; i++)
			tick(1);
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clock_in) begin
		if ((live_ok_out | live_refused_out) === 1'b1) begin
			if (expq.size() == 0) begin
				chk(9'h1FF, 9'h000);
			end else begin
				e = expq.pop_front();
				chk_read(e);
			end
		end
	end

	initial begin
		tick(20000);
		miscompares++;
		wrap_up();
	end

	initial begin
		void'($urandom(70));
		{resetn_in, int_prog_valid_in, cart_present_in, cart_protect_in} = 4'h0;
		{host_wr_in, host_start_in, host_stop_in} = 3'h0;
		{host_pw_valid_in, host_rd_in, slow} = 3'h0;
		cable_in = 1'b1;
		pin_in = 8'h00;
		host_addr_in = 3'h0;
		host_data_in = 8'h00;
		host_pw_in = 16'h0000;
		cart_password_in = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			w = 8'($urandom);
			w[7:6] = i[1:0];
			prog[i*8 +: 8] = w;
			card[i*8 +: 8] = 8'($urandom);
		end
		boot(1'b0, 1'b0, 1'b0);
		chk_lamps(2'h2);
		rd(1'b0, 8'h00);
		for (int i = 0; i < 8; i++)
			hwr(i[2:0], prog[i*8 +: 8]);
		// without the cable a start must be ignored
		cable_in <= 1'b0;
		tick(3);
		hop(0, 16'h0000);
		tick(2);
		chk_lamps(2'h2);
		cable_in <= 1'b1;
		tick(3);
		hop(0, 16'h0000);
		tick(2);
		chk_lamps(2'h1);
		repeat (4) begin
			pin_in <= 8'($urandom);
			tick(40);
			chk_pins(prog);
			rd(1'b1, fn(prog, pin_in));
		end
		hop(1, 16'h0000);
		tick(2);
		chk_lamps(2'h2);
		boot(1'b1, 1'b0, 1'b0);
		chk_lamps(2'h1);
		cart_password_in <= 16'($urandom);
		slow <= 1'b1;
		boot(1'b1, 1'b1, 1'b1);
		chk_lamps(2'h1);
		tick(40);
		chk_pins(card);
		rd(1'b0, 8'h00);
		hop(2, ~cart_password_in);
		rd(1'b0, 8'h00);
		hop(2, cart_password_in);
		rd(1'b1, fn(card, pin_in));
		cart_present_in <= 1'b0;
		tick(6);
		chk_lamps(2'h2);
		hop(0, 16'h0000);
		tick(2);
		chk_lamps(2'h2);
		tick(4);
		chk({1'b0, expq.size() == 0 ? 8'h00 : 8'hFF}, 9'h000);
		wrap_up();
	end
endmodule // tb
`default_nettype wire
